/* design/sfwp_core.sv */
// Summary of operation
// RULE_01: Unlock instruction sets the write unlock latch.
// RULE_02: Host unlocks before every write-type instruction.
// RULE_03: Relock instruction clears the write unlock latch.
// RULE_04: Latch clears at power-up and write completion.
// RULE_05: Host frames unlock/relock as one byte.
// RULE_06: Status read works anytime, repeats while clocked.
// RULE_07: Host should poll busy before new instructions.
// RULE_08: Busy flag is one during self-timed cycles.
// RULE_09: Latch clear refuses status write, program, erase.
// RULE_10: Protect level set only by status write.
// RULE_11: Chip wipe only with protect level zero.
// RULE_12: Protected area refuses writes, unprotected accepts some.
// RULE_13: Lock bit and guard low freeze status.
// RULE_14: Host sends status write with one byte.
// RULE_15: Bits 6,5,1,0 unwritten; 6,5 read zero.
// RULE_16: Status write needs select high after byte.
// RULE_17: Valid status write runs timed busy cycle.
// RULE_18: Lock bit clear: latch alone permits status write.
// RULE_19: Lock bit set: guard high permits, low refuses.
// RULE_20: Hard lock entered in either order.
// RULE_21: Hard lock left only by guard going high.
// RULE_22: Status layout busy0 latch1 level2-4 lock7.
// RULE_23: Opcodes 06 unlock, 04 relock, 05 read.
// RULE_24: Opcode 01 status write, MSB first.
// RULE_25: Select rises on byte boundary or rejected.
`timescale 1ns/1ps
`default_nettype none

module sfwp_core #(
    parameter int unsigned STATUS_WRITE_CYCLES = sfwp_pkg::STATUS_WRITE_CYCLES_DEF,
    parameter int unsigned ARRAY_CYCLES        = sfwp_pkg::ARRAY_CYCLES_DEF
) (
    // Core clock, reset and clock enable.
    input  wire logic                      CORE_CLK,
    input  wire logic                      RST,
    input  wire logic                      CE,
    // Serial link from the host.
    input  wire logic                      LINK_SCK,
    input  wire logic                      CS_N,
    input  wire logic                      SI,
    output logic                           SO,
    output logic                           SO_OE,
    // Guard pin, low requests hardware lock.
    input  wire logic                      GUARD_N,
    // Status view.
    output logic [7:0]                     STATUS,
    output logic                           HARD_LOCK,
    output logic                           SOFT_GUARD,
    // Array engine request.
    output logic                           ARRAY_GO,
    output sfwp_pkg::sfwp_array_req_t      ARRAY_REQ
);

    // ----------------------------------------------------------------
    // Link domain: frame capture on the rising serial clock edge.
    // ----------------------------------------------------------------
    logic                  link_clr;
    logic                  started_reg;
    logic [7:0]            shift_reg;
    logic [7:0]            shift_next;
    logic                  frame_tog_reg;
    sfwp_pkg::sfwp_frame_t frame_reg;
    logic [7:0]            status_link;
    logic [7:0]            snap_reg;
    logic                  so_reg;
    logic                  so_en_reg;

    // Select high ends the frame.
    assign link_clr   = CS_N | RST;
    assign shift_next = {shift_reg[6:0], SI};

    // Marks a frame that has been clocked.
    always_ff @(posedge LINK_SCK or posedge link_clr) begin
        if (link_clr) begin
            started_reg <= 1'b0;
        end else begin
            started_reg <= 1'b1;
        end
    end

    // Shifts bits in and counts bits and bytes.
    always_ff @(posedge LINK_SCK or posedge RST) begin
        if (RST) begin
            shift_reg     <= 8'h00;
            frame_tog_reg <= 1'b0;
            frame_reg     <= '0;
        end else if (!started_reg) begin
            shift_reg          <= {7'h00, SI};
            frame_reg.bit_idx  <= 3'h1;
            frame_reg.byte_cnt <= 3'h0;
            frame_tog_reg      <= ~frame_tog_reg; // Announces a clocked frame.
        end else begin
            shift_reg         <= shift_next; // RULE_24
            frame_reg.bit_idx <= frame_reg.bit_idx + 3'h1;
            if (frame_reg.bit_idx == 3'h7) begin
                if (frame_reg.byte_cnt == 3'h0) begin
                    frame_reg.opcode <= shift_next; // RULE_23
                end
                if (frame_reg.byte_cnt == sfwp_pkg::BYTES_OPCODE_ONLY) begin
                    frame_reg.second <= shift_next;
                end
                if (frame_reg.byte_cnt != sfwp_pkg::BYTES_SATURATED) begin
                    frame_reg.byte_cnt <= frame_reg.byte_cnt + 3'h1;
                end
            end
        end
    end

    // Brings the status byte into the link domain.
    sfwp_sync #(
        .W         (8),
        .RESET_VAL (8'h00)
    ) u_status_sync (
        .clk (LINK_SCK),
        .clr (1'b0),
        .en  (1'b1),
        .d   (STATUS),
        .q   (status_link)
    );

    // Shifts the status byte out on the falling edge.
    always_ff @(negedge LINK_SCK or posedge link_clr) begin
        if (link_clr) begin
            so_reg    <= 1'b0;
            so_en_reg <= 1'b0;
            snap_reg  <= 8'h00;
        end else if (started_reg && frame_reg.byte_cnt != 3'h0 &&
                     frame_reg.opcode == sfwp_pkg::OP_STATUS_READ) begin
            so_en_reg <= 1'b1; // RULE_06
            if (frame_reg.bit_idx == 3'h0) begin
                snap_reg <= status_link;
                so_reg   <= status_link[7];
            end else begin
                so_reg   <= snap_reg[~frame_reg.bit_idx];
            end
        end
    end

    assign SO    = so_reg;
    assign SO_OE = so_en_reg;

    // ----------------------------------------------------------------
    // Core domain: pin synchronisers and frame end detection.
    // ----------------------------------------------------------------
    logic cs_n_s;
    logic guard_n_s;
    logic tog_s;
    logic cs_prev_reg;
    logic tog_seen_reg;
    logic frame_end;

    // Select, guard and frame toggle pass two flip-flops.
    sfwp_sync #(
        .W         (3),
        .RESET_VAL (sfwp_pkg::PIN_SYNC_INIT)
    ) u_pin_sync (
        .clk (CORE_CLK),
        .clr (RST),
        .en  (CE),
        .d   ({CS_N, GUARD_N, frame_tog_reg}),
        .q   ({cs_n_s, guard_n_s, tog_s})
    );

    // Remembers select and the last frame toggle.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            cs_prev_reg  <= 1'b1;
            tog_seen_reg <= 1'b0;
        end else if (CE) begin
            cs_prev_reg <= cs_n_s;
            if (cs_n_s && !cs_prev_reg) begin
                tog_seen_reg <= tog_s;
            end
        end
    end

    // A frame ends on select rising after at least one clock edge.
    assign frame_end = cs_n_s & ~cs_prev_reg & (tog_s != tog_seen_reg);

    // ----------------------------------------------------------------
    // Core domain: decode and protection checks.
    // ----------------------------------------------------------------
    sfwp_pkg::sfwp_state_t state_reg;
    logic                  wel_reg;
    logic [2:0]            level_reg;
    logic                  lock_reg;
    logic [31:0]           cnt_reg;
    logic                  busy;
    logic                  aligned;
    logic                  is_unlock;
    logic                  is_relock;
    logic                  is_status_write;
    logic                  is_page_write;
    logic                  is_region_clear;
    logic                  is_chip_wipe;
    logic                  hard_lock;
    logic                  sector_locked;
    logic                  status_write_ok;
    logic                  array_ok;
    logic                  cycle_done;

    // Reports whether the protect level covers a sector.
    function automatic logic level_covers(input logic [2:0] level, input logic [2:0] sector);
        logic hit;
        hit = 1'b0;
        case (level)
            3'h0:    hit = 1'b0;
            3'h1:    hit = (sector == 3'h7);
            3'h2:    hit = (sector >= 3'h6);
            3'h3:    hit = (sector >= 3'h4);
            default: hit = 1'b1;
        endcase
        return hit;
    endfunction

    // The frame fields are stable here: no clock edges while select is high.
    assign busy            = (state_reg != sfwp_pkg::ST_IDLE);
    assign aligned         = (frame_reg.bit_idx == 3'h0); // RULE_25
    assign is_unlock       = aligned && frame_reg.byte_cnt != 3'h0 &&
                             frame_reg.opcode == sfwp_pkg::OP_UNLOCK; // RULE_23 RULE_25
    assign is_relock       = aligned && frame_reg.byte_cnt != 3'h0 &&
                             frame_reg.opcode == sfwp_pkg::OP_RELOCK; // RULE_23 RULE_25
    assign is_status_write = aligned && frame_reg.byte_cnt == sfwp_pkg::BYTES_STATUS_WRITE &&
                             frame_reg.opcode == sfwp_pkg::OP_STATUS_WRITE; // RULE_16 RULE_24
    assign is_page_write   = aligned && frame_reg.byte_cnt >= sfwp_pkg::BYTES_PAGE_MIN &&
                             frame_reg.opcode == sfwp_pkg::OP_PAGE_WRITE;
    assign is_region_clear = aligned && frame_reg.byte_cnt == sfwp_pkg::BYTES_REGION_CLEAR &&
                             frame_reg.opcode == sfwp_pkg::OP_REGION_CLEAR;
    assign is_chip_wipe    = aligned && frame_reg.byte_cnt == sfwp_pkg::BYTES_OPCODE_ONLY &&
                             frame_reg.opcode == sfwp_pkg::OP_CHIP_WIPE;

    // Hard lock holds exactly while the lock bit is set and the guard is low.
    assign hard_lock       = lock_reg & ~guard_n_s; // RULE_13 RULE_20 RULE_21

    // Sector is the low bits of the first address byte.
    assign sector_locked   = level_covers(level_reg, frame_reg.second[2:0]); // RULE_12

    // Status write needs the latch and no hard lock.
    assign status_write_ok = is_status_write & wel_reg & ~hard_lock; // RULE_09 RULE_18 RULE_19

    // Array writes need the latch and an open target.
    assign array_ok        = wel_reg & (((is_page_write | is_region_clear) & ~sector_locked) |
                             (is_chip_wipe & (level_reg == 3'h0))); // RULE_09 RULE_10 RULE_11 RULE_12

    assign cycle_done      = busy && (cnt_reg == 32'h0);

    // ----------------------------------------------------------------
    // Core domain: self-timed cycle sequencer.
    // ----------------------------------------------------------------

    // Starts and times the self-timed cycle.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            state_reg <= sfwp_pkg::ST_IDLE;
            cnt_reg   <= 32'h0;
        end else if (CE) begin
            case (state_reg)
                sfwp_pkg::ST_IDLE: begin
                    if (frame_end && status_write_ok) begin
                        state_reg <= sfwp_pkg::ST_STATUS_CYC; // RULE_17
                        cnt_reg   <= 32'(STATUS_WRITE_CYCLES - 1);
                    end else if (frame_end && array_ok) begin
                        state_reg <= sfwp_pkg::ST_ARRAY_CYC;
                        cnt_reg   <= 32'(ARRAY_CYCLES - 1);
                    end
                end
                sfwp_pkg::ST_STATUS_CYC, sfwp_pkg::ST_ARRAY_CYC: begin
                    if (cnt_reg == 32'h0) begin
                        state_reg <= sfwp_pkg::ST_IDLE; // RULE_08
                    end else begin
                        cnt_reg <= cnt_reg - 32'h1;
                    end
                end
                default: begin
                    state_reg <= sfwp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Write unlock latch.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            wel_reg <= 1'b0; // RULE_04
        end else if (CE) begin
            if (cycle_done) begin
                wel_reg <= 1'b0; // RULE_04 RULE_17
            end else if (frame_end && !busy && is_unlock) begin
                wel_reg <= 1'b1; // RULE_01
            end else if (frame_end && !busy && is_relock) begin
                wel_reg <= 1'b0; // RULE_03 RULE_04
            end
        end
    end

    // Non-volatile bits change only by a status write.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            level_reg <= sfwp_pkg::PROTECT_LEVEL_INIT;
            lock_reg  <= sfwp_pkg::STATUS_LOCK_INIT; // RULE_18
        end else if (CE) begin
            if (frame_end && !busy && status_write_ok) begin
                level_reg <= frame_reg.second[sfwp_pkg::BIT_LEVEL_HI:sfwp_pkg::BIT_LEVEL_LO]; // RULE_10
                lock_reg  <= frame_reg.second[sfwp_pkg::BIT_LOCK]; // RULE_13 RULE_15
            end
        end
    end

    // Hands an accepted array write to the engine.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ARRAY_GO  <= 1'b0;
            ARRAY_REQ <= '0;
        end else if (CE) begin
            ARRAY_GO <= frame_end && !busy && !status_write_ok && array_ok;
            if (frame_end && !busy && array_ok) begin
                ARRAY_REQ.sector <= frame_reg.second[2:0];
                if (is_page_write) begin
                    ARRAY_REQ.kind <= sfwp_pkg::KIND_PAGE_WRITE;
                end else if (is_region_clear) begin
                    ARRAY_REQ.kind <= sfwp_pkg::KIND_REGION_CLEAR;
                end else begin
                    ARRAY_REQ.kind <= sfwp_pkg::KIND_CHIP_WIPE;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Core domain: registered status view.
    // ----------------------------------------------------------------

    // Assembles the status byte; bits 6 and 5 always read zero.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            STATUS     <= 8'h00;
            HARD_LOCK  <= 1'b0;
            SOFT_GUARD <= 1'b1;
        end else if (CE) begin
            STATUS     <= {lock_reg, 2'b00, level_reg, wel_reg, busy}; // RULE_15 RULE_22 RULE_08
            HARD_LOCK  <= hard_lock; // RULE_20 RULE_21
            SOFT_GUARD <= ~hard_lock;
        end
    end

endmodule

`default_nettype wire

/* design/sfwp_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------------------------
// Two flip-flop synchroniser per bit.
// --------------------------------------------------------------------
module sfwp_sync #(
    parameter int unsigned   W         = 1,
    parameter logic [W-1:0]  RESET_VAL = '0
) (
    // Destination clock and controls.
    input  wire logic         clk,
    input  wire logic         clr,
    input  wire logic         en,
    // Levels in and out.
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_reg;
            logic hold_reg;
            // The first stage feeds only the second stage.
            always_ff @(posedge clk) begin
                if (clr) begin
                    meta_reg <= RESET_VAL[i];
                    hold_reg <= RESET_VAL[i];
                end else if (en) begin
                    meta_reg <= d[i];
                    hold_reg <= meta_reg;
                end
            end
            assign q[i] = hold_reg;
        end
    endgenerate

endmodule

`default_nettype wire

/* pkg/sfwp_pkg.sv */
package sfwp_pkg;

    // ----------------------------------------------------------------
    // Instruction opcodes, shifted most significant bit first.
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_UNLOCK       = 8'h06;
    localparam logic [7:0] OP_RELOCK       = 8'h04;
    localparam logic [7:0] OP_STATUS_READ  = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_PAGE_WRITE   = 8'h02;
    localparam logic [7:0] OP_REGION_CLEAR = 8'hd8;
    localparam logic [7:0] OP_CHIP_WIPE    = 8'hc7;

    // ----------------------------------------------------------------
    // Status register layout.
    // ----------------------------------------------------------------
    localparam int unsigned BIT_BUSY     = 0;
    localparam int unsigned BIT_UNLOCK   = 1;
    localparam int unsigned BIT_LEVEL_LO = 2;
    localparam int unsigned BIT_LEVEL_HI = 4;
    localparam int unsigned BIT_LOCK     = 7;

    // Delivered state of the non-volatile bits.
    localparam logic [2:0] PROTECT_LEVEL_INIT = 3'h0;
    localparam logic       STATUS_LOCK_INIT   = 1'h0;

    // ----------------------------------------------------------------
    // Frame lengths in whole bytes (the byte counter saturates at 7).
    // ----------------------------------------------------------------
    localparam logic [2:0] BYTES_OPCODE_ONLY  = 3'h1;
    localparam logic [2:0] BYTES_STATUS_WRITE = 3'h2;
    localparam logic [2:0] BYTES_REGION_CLEAR = 3'h4;
    localparam logic [2:0] BYTES_PAGE_MIN     = 3'h5;
    localparam logic [2:0] BYTES_SATURATED    = 3'h7;

    // Self-timed cycle lengths in core clock cycles.
    localparam int unsigned STATUS_WRITE_CYCLES_DEF = 1000;
    localparam int unsigned ARRAY_CYCLES_DEF        = 2000;

    // Reset value of the pin synchroniser: select high, guard high, toggle 0.
    localparam logic [2:0] PIN_SYNC_INIT = 3'h6;

    // ----------------------------------------------------------------
    // Types.
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE       = 3'b001,
        ST_STATUS_CYC = 3'b010,
        ST_ARRAY_CYC  = 3'b100
    } sfwp_state_t;

    typedef enum logic [1:0] {
        KIND_PAGE_WRITE   = 2'h0,
        KIND_REGION_CLEAR = 2'h1,
        KIND_CHIP_WIPE    = 2'h2
    } sfwp_kind_t;

    // What the link side has captured of the current or last frame.
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] second;
        logic [2:0] bit_idx;
        logic [2:0] byte_cnt;
    } sfwp_frame_t;

    // Request handed to the array engine.
    typedef struct packed {
        sfwp_kind_t kind;
        logic [2:0] sector;
    } sfwp_array_req_t;

endpackage

/* testbench/sfwp_core_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Port checks.
// ------------------------------------------------------------
module sfwp_core_asserts #(
    parameter int unsigned STATUS_WRITE_CYCLES = sfwp_pkg::STATUS_WRITE_CYCLES_DEF,
    parameter int unsigned ARRAY_CYCLES        = sfwp_pkg::ARRAY_CYCLES_DEF
) (
    // Core clock and reset.
    input wire logic                      CORE_CLK,
    input wire logic                      RST,
    // Link select and enable.
    input wire logic                      CS_N,
    input wire logic                      SO_OE,
    // Status view and array request.
    input wire logic [7:0]                STATUS,
    input wire logic                      HARD_LOCK,
    input wire logic                      SOFT_GUARD,
    input wire logic                      ARRAY_GO,
    input wire sfwp_pkg::sfwp_array_req_t ARRAY_REQ
);
    localparam int unsigned BUSY_MIN = (STATUS_WRITE_CYCLES < ARRAY_CYCLES) ? STATUS_WRITE_CYCLES : ARRAY_CYCLES;
    localparam int unsigned BUSY_MAX = (STATUS_WRITE_CYCLES < ARRAY_CYCLES) ? ARRAY_CYCLES : STATUS_WRITE_CYCLES;
    logic [31:0] busy_run_reg;

    // Counts cycles of busy.
    always_ff @(posedge CORE_CLK) begin
        if (RST || !STATUS[0]) begin
            busy_run_reg <= 32'h0;
        end else begin
            busy_run_reg <= busy_run_reg + 32'h1;
        end
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    a_guard_inverse:
        assert property (SOFT_GUARD == !HARD_LOCK) else $error("guard mismatch");
    a_lock_needs_bit:
        assert property (HARD_LOCK |-> STATUS[7]) else $error("lock without bit");
    a_reserved_zero:
        assert property (STATUS[6:5] == 2'h0) else $error("reserved bits set");
    a_go_sets_busy:
        assert property (ARRAY_GO |=> !ARRAY_GO ##[0:1] STATUS[0]) else $error("go without busy");
    a_go_needs_latch:
        assert property (ARRAY_GO |-> $past(STATUS[1:0], 2) == 2'h2) else $error("go without latch");
    a_wipe_unprotected:
        assert property (ARRAY_GO && ARRAY_REQ.kind == sfwp_pkg::KIND_CHIP_WIPE |-> STATUS[4:2] == 3'h0)
            else $error("wipe protected");
    a_level_frozen:
        assert property (HARD_LOCK |=> $stable({STATUS[7], STATUS[4:2]})) else $error("locked bits changed");
    a_write_starts_busy:
        assert property ($changed({STATUS[7], STATUS[4:2]}) |-> STATUS[0] && $past(STATUS[1]))
            else $error("bits changed idle");
    a_latch_drop_end:
        assert property ($fell(STATUS[0]) |-> !STATUS[1]) else $error("latch kept");
    a_busy_length:
        assert property ($fell(STATUS[0]) |-> busy_run_reg >= BUSY_MIN - 1 && busy_run_reg <= BUSY_MAX + 1)
            else $error("busy length wrong");
    a_quiet_unselected:
        assert property (CS_N |-> !SO_OE) else $error("driven unselected");
    a_latch_rise_idle:
        assert property ($rose(STATUS[1]) |-> !STATUS[0]) else $error("latch set busy");
endmodule

bind sfwp_core sfwp_core_asserts #(
    .STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES),
    .ARRAY_CYCLES(ARRAY_CYCLES)
) chk_u (
    .CORE_CLK(CORE_CLK), .RST(RST), .CS_N(CS_N), .SO_OE(SO_OE), .STATUS(STATUS),
    .HARD_LOCK(HARD_LOCK), .SOFT_GUARD(SOFT_GUARD), .ARRAY_GO(ARRAY_GO), .ARRAY_REQ(ARRAY_REQ)
);

`default_nettype wire

/* testbench/sfwp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Serial host; clock idles low.
// ------------------------------------------------------------
module sfwp_host_model (
    // Pins toward the device.
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    // Answer from the device.
    input  wire logic so,
    input  wire logic so_oe
);
    // Idle lines.
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end

    // Sends n bits MSB first; rx keeps the last byte.
    task automatic xfer(input logic [31:0] tx, input int n, output logic [7:0] rx);
        rx = 8'hxx;
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            si = tx[31 - i];
            #62.5 sck = 1'b1;
            rx = {rx[6:0], so_oe ? so : 1'bx};
            #62.5 sck = 1'b0;
        end
        #62.5 cs_n = 1'b1;
        si = ~si; // Released line shows the inverse.
        #100;
    endtask
endmodule

`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Self-checking bench.
// ------------------------------------------------------------
module tb;
    localparam int unsigned BUSY_CYC = 400;
    logic                      core_clk;
    logic                      rst;
    logic                      guard_n;
    wire logic                 sck, cs_n, si, so, so_oe;
    logic [7:0]                status;
    logic                      hard_lock, soft_guard, array_go;
    sfwp_pkg::sfwp_array_req_t array_req, last_req;
    logic [7:0]                rx;
    int                        n_mismatch, checks, n_go;

    sfwp_core #(.STATUS_WRITE_CYCLES(BUSY_CYC), .ARRAY_CYCLES(BUSY_CYC)) dut_u (
        .CORE_CLK(core_clk), .RST(rst), .CE(1'b1), .LINK_SCK(sck), .CS_N(cs_n), .SI(si), .SO(so),
        .SO_OE(so_oe), .GUARD_N(guard_n), .STATUS(status), .HARD_LOCK(hard_lock),
        .SOFT_GUARD(soft_guard), .ARRAY_GO(array_go), .ARRAY_REQ(array_req));

    sfwp_host_model host_u (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

    // Core clock of 8 ns.
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Counts array starts.
    always @(posedge core_clk) begin
        if (array_go === 1'b1) begin
            n_go++;
            last_req = array_req;
        end
    end

    // Compares a value.
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Prints the verdict and ends.
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Frame helpers.
    task automatic op(input logic [7:0] code, input int n);
        host_u.xfer({code, 24'h0}, n, rx);
    endtask
    task automatic wr(input logic [7:0] d);
        host_u.xfer({sfwp_pkg::OP_STATUS_WRITE, d, 16'h0}, 16, rx);
    endtask
    task automatic set_guard(input logic v);
        @(posedge core_clk);
        #1 guard_n = v;
        repeat (5) @(posedge core_clk);
        #1;
    endtask

    // Waits, bounded, for busy to clear.
    task automatic wait_idle();
        int i;
        for (i = 0; i < 2000 && status[0] !== 1'b0; i++) begin
            @(posedge core_clk);
            #1;
        end
        if (i == 2000) begin
            n_mismatch++;
            report_and_stop();
        end
        repeat (4) @(posedge core_clk);
        #1;
    endtask

    // Latch set, cleared and refused.
    task automatic t_latch();
        check("reset status", status, 8'h00);
        check("reset flags", {6'h0, hard_lock, soft_guard}, 8'h01);
        op(sfwp_pkg::OP_UNLOCK, 7);
        check("cut unlock", status, 8'h00);
        op(sfwp_pkg::OP_UNLOCK, 8);
        check("unlock", status, 8'h02);
        op(sfwp_pkg::OP_STATUS_READ, 24);
        check("read repeat", rx, 8'h02);
        op(sfwp_pkg::OP_RELOCK, 8);
        check("relock", status, 8'h00);
        wr(8'h9c);
        check("write no latch", status, 8'h00);
        op(sfwp_pkg::OP_CHIP_WIPE, 8);
        check("wipe no latch", n_go[7:0], 8'h00);
    endtask

    // Array starts against the protect level.
    task automatic t_array();
        op(sfwp_pkg::OP_UNLOCK, 8);
        op(sfwp_pkg::OP_CHIP_WIPE, 8);
        check("wipe go", n_go[7:0], 8'h01);
        check("wipe kind", {6'h0, last_req.kind}, {6'h0, sfwp_pkg::KIND_CHIP_WIPE});
        wait_idle();
        check("wipe end", status, 8'h00);
        op(sfwp_pkg::OP_UNLOCK, 8);
        wr(8'h04);
        check("level busy", status, 8'h07);
        wait_idle();
        check("level set", status, 8'h04);
        op(sfwp_pkg::OP_UNLOCK, 8);
        host_u.xfer({sfwp_pkg::OP_REGION_CLEAR, 8'h07, 16'h0}, 32, rx);
        check("protected clear", n_go[7:0], 8'h01);
        host_u.xfer({sfwp_pkg::OP_REGION_CLEAR, 8'h06, 16'h0}, 32, rx);
        check("open clear", n_go[7:0], 8'h02);
        check("clear req", {3'h0, last_req}, {3'h0, sfwp_pkg::KIND_REGION_CLEAR, 3'h6});
        wait_idle();
        op(sfwp_pkg::OP_UNLOCK, 8);
        op(sfwp_pkg::OP_CHIP_WIPE, 8);
        check("wipe protected", n_go[7:0], 8'h02);
        host_u.xfer({sfwp_pkg::OP_STATUS_WRITE, 24'h0}, 24, rx);
        check("long write", status, 8'h06);
    endtask

    // Lock bit against guard pin.
    task automatic t_hard_lock();
        wr(8'hff);
        check("full write", status, 8'h9f);
        op(sfwp_pkg::OP_STATUS_READ, 24);
        check("busy read", rx, 8'h9f);
        wait_idle();
        check("full end", status, 8'h9c);
        set_guard(1'b0);
        check("lock flags", {6'h0, hard_lock, soft_guard}, 8'h02);
        op(sfwp_pkg::OP_UNLOCK, 8);
        wr(8'h00);
        check("locked write", status, 8'h9e);
        set_guard(1'b1);
        check("unlock flags", {6'h0, hard_lock, soft_guard}, 8'h01);
        wr(8'h00);
        wait_idle();
        check("guard high write", status, 8'h00);
        set_guard(1'b0);
        op(sfwp_pkg::OP_UNLOCK, 8);
        wr(8'h04);
        wait_idle();
        check("bit clear write", status, 8'h04);
        op(sfwp_pkg::OP_UNLOCK, 8);
        wr(8'h80);
        wait_idle();
        check("late lock", {status[7], 5'h0, hard_lock, soft_guard}, 8'h82);
    endtask

    // Reset, then scenarios.
    initial begin
        rst = 1'b1;
        guard_n = 1'b1;
        checks = 0;
        n_mismatch = 0;
        n_go = 0;
        repeat (2) @(posedge core_clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        t_latch();
        t_array();
        t_hard_lock();
        report_and_stop();
    end
endmodule

`default_nettype wire
